/* File: operand_address_decode.sv */
// operand addressing decoder: modrm, displacement, immediate, effective address, flag word
`timescale 1ns/1ps
// Contract
// - selector 011: base pointer plus destination index
// - selector 100: source index plus displacement
// - selector 101: destination index plus displacement
// - selector 110 with displacement: base pointer
// - selector 111: base word register plus displacement
// - displacement after second byte, immediate after
// - flag word handled as one 16-bit quantity
// - form 10: low byte then high byte
// - selector 000: base word plus source index
module operand_address_decode
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic byte_valid,
    input wire logic [7:0] byte_data,
    input wire logic first_byte,
    input wire operand_address_decode_pkg::opcode_info_t op_info,
    input wire operand_address_decode_pkg::addr_regs_t regs,
    input wire logic [15:0] flag_word_in,
    output operand_address_decode_pkg::decode_out_t dec_out,
    output logic [15:0] flag_word_out,
    output logic flag_word_valid
);
    import operand_address_decode_pkg::*;

    typedef enum logic [2:0] {st_idle, st_modrm, st_disp_lo, st_disp_hi, st_imm} state_t;

    state_t state_r;
    opcode_info_t info_r;
    logic [7:0] modrm_r;
    logic [7:0] modrm_nxt;
    logic [15:0] disp_r;
    logic [15:0] imm_r;
    logic [1:0] imm_cnt_r;
    logic [1:0] mode;
    logic [2:0] sel;
    logic [15:0] ea_nxt;
    logic [15:0] disp_nxt;
    logic finish;
    logic need_disp;
    logic disp_wide;

    assign mode = modrm_nxt[mod_lsb +: 2];
    assign sel = modrm_nxt[rm_lsb +: 3];
    // direct form: mode 00 with selector 110 carries a 16-bit address instead of base pointer
    assign need_disp = (mode == mod_disp8) || (mode == mod_disp16) || (mode == mod_disp0 && sel == rm_bp);
    assign disp_wide = (mode == mod_disp16) || (mode == mod_disp0 && sel == rm_bp);

    // the selector byte counts in its own cycle, so a two-byte instruction
    // completes without waiting one more clock for the captured copy
    always_comb
    begin
        modrm_nxt = modrm_r;
        if (byte_valid && !first_byte && state_r == st_modrm)
            modrm_nxt = byte_data;
    end

    // byte sequencer: opcode, selector byte, displacement, then immediate
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r <= st_idle;
            info_r <= '0;
            modrm_r <= 8'h00;
            disp_r <= word_rst;
            imm_r <= word_rst;
            imm_cnt_r <= 2'h0;
        end
        else if (byte_valid)
        begin
            if (first_byte)
            begin
                info_r <= op_info;
                modrm_r <= 8'h00;
                disp_r <= word_rst;
                imm_r <= word_rst;
                imm_cnt_r <= 2'h0;
                if (op_info.has_modrm)
                    state_r <= st_modrm;
                else if (op_info.imm_bytes != 2'h0)
                    state_r <= st_imm;
                else
                    state_r <= st_idle;
            end
            else
            begin
                unique case (state_r)
                    st_idle:
                        state_r <= st_idle;
                    st_modrm:
                    begin
                        modrm_r <= byte_data;
                        if (byte_data[mod_lsb +: 2] != mod_reg
                            && (byte_data[mod_lsb +: 2] != mod_disp0 || byte_data[rm_lsb +: 3] == rm_bp))
                            state_r <= st_disp_lo;
                        else if (info_r.imm_bytes != 2'h0)
                            state_r <= st_imm;
                        else
                            state_r <= st_idle;
                    end
                    st_disp_lo:
                    begin
                        // short form sign-extends; wide form waits for the high byte
                        disp_r <= {{8{byte_data[7]}}, byte_data};
                        if (disp_wide)
                            state_r <= st_disp_hi;
                        else if (info_r.imm_bytes != 2'h0)
                            state_r <= st_imm;
                        else
                            state_r <= st_idle;
                    end
                    st_disp_hi:
                    begin
                        disp_r <= {byte_data, disp_r[7:0]};
                        state_r <= (info_r.imm_bytes != 2'h0) ? st_imm : st_idle;
                    end
                    st_imm:
                    begin
                        if (imm_cnt_r == 2'h0)
                            imm_r <= {8'h00, byte_data};
                        else
                            imm_r <= {byte_data, imm_r[7:0]};
                        imm_cnt_r <= imm_cnt_r + 2'h1;
                        if (imm_cnt_r + 2'h1 >= info_r.imm_bytes || imm_cnt_r + 2'h1 >= imm_max[1:0])
                            state_r <= st_idle;
                    end
                    default:
                        state_r <= st_idle;
                endcase
            end
        end
    end

    // last byte of the instruction was taken this cycle
    always_comb
    begin
        finish = 1'b0;
        if (byte_valid && !first_byte)
        begin
            unique case (state_r)
                st_modrm:
                    finish = !((byte_data[mod_lsb +: 2] != mod_reg
                        && (byte_data[mod_lsb +: 2] != mod_disp0 || byte_data[rm_lsb +: 3] == rm_bp))
                        || info_r.imm_bytes != 2'h0);
                st_disp_lo:
                    finish = !disp_wide && info_r.imm_bytes == 2'h0;
                st_disp_hi:
                    finish = info_r.imm_bytes == 2'h0;
                st_imm:
                    finish = (imm_cnt_r + 2'h1 >= info_r.imm_bytes) || (imm_cnt_r + 2'h1 >= imm_max[1:0]);
                default:
                    finish = 1'b0;
            endcase
        end
        // an opcode byte never completes: a single-byte opcode gives no result pulse
    end

    // completed displacement, including a byte arriving this cycle
    always_comb
    begin
        disp_nxt = need_disp ? disp_r : word_rst;
        if (byte_valid && !first_byte && state_r == st_disp_lo)
            disp_nxt = {{8{byte_data[7]}}, byte_data};
        else if (byte_valid && !first_byte && state_r == st_disp_hi)
            disp_nxt = {byte_data, disp_r[7:0]};
    end

    // 16-bit sums wrap; relocation is applied downstream
    always_comb
    begin
        unique case (sel)
            rm_bx_si: ea_nxt = 16'(regs.base_word_register + regs.source_index + disp_nxt);
            rm_bx_di: ea_nxt = 16'(regs.base_word_register + regs.destination_index + disp_nxt);
            rm_bp_si: ea_nxt = 16'(regs.base_pointer + regs.source_index + disp_nxt);
            rm_bp_di: ea_nxt = 16'(regs.base_pointer + regs.destination_index + disp_nxt);
            rm_si: ea_nxt = 16'(regs.source_index + disp_nxt);
            rm_di: ea_nxt = 16'(regs.destination_index + disp_nxt);
            rm_bp: ea_nxt = (mode == mod_disp0) ? disp_nxt : 16'(regs.base_pointer + disp_nxt);
            rm_bx: ea_nxt = 16'(regs.base_word_register + disp_nxt);
        endcase
    end

    // result register, pulses valid for one cycle when the instruction completes
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            dec_out <= '0;
        else
        begin
            dec_out.valid <= finish;
            if (finish)
            begin
                dec_out.is_memory <= info_r.has_modrm && mode != mod_reg && !first_byte;
                dec_out.effective_address <= ea_nxt;
                dec_out.displacement <= disp_nxt;
                dec_out.modrm <= modrm_nxt;
                if (byte_valid && state_r == st_imm)
                    dec_out.immediate <= (imm_cnt_r == 2'h0) ? {8'h00, byte_data} : {byte_data, imm_r[7:0]};
                else
                    dec_out.immediate <= imm_r;
            end
        end
    end

    // flag word moves whole, never bit by bit
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            flag_word_out <= word_rst;
            flag_word_valid <= 1'b0;
        end
        else
        begin
            flag_word_valid <= byte_valid && first_byte && op_info.flag_word_op;
            if (byte_valid && first_byte && op_info.flag_word_op)
                flag_word_out <= flag_word_in;
        end
    end
endmodule

/* File: operand_address_decode_bench.sv */
// testbench: drives instruction bytes and checks decoded operand addresses
`timescale 1ns/1ps
module operand_address_decode_bench;
    import operand_address_decode_pkg::*;
    logic clk = 0, rst_n = 0, byte_valid = 0, first_byte = 0;
    logic [7:0] byte_data = 8'h00;
    opcode_info_t op_info = '0;
    addr_regs_t regs = '0;
    logic [15:0] flag_word_in = 16'h0000, flag_word_out;
    decode_out_t dec_out;
    logic flag_word_valid;
    logic [57:0] e;
    logic [57:0] exp_q[$];
    logic [15:0] flag_q[$];
    int errors = 0, check_count = 0;
    always #4 clk = ~clk;
    operand_address_decode uut (.clk(clk), .rst_n(rst_n), .byte_valid(byte_valid), .byte_data(byte_data),
        .first_byte(first_byte), .op_info(op_info), .regs(regs), .flag_word_in(flag_word_in),
        .dec_out(dec_out), .flag_word_out(flag_word_out), .flag_word_valid(flag_word_valid));
    task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    begin
        check_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    end
    endtask
    task end_sim;
    begin
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    end
    endtask
    task put(input logic [7:0] b, input logic f);
    begin
        byte_valid <= 1'b1;
        byte_data <= b;
        first_byte <= f;
        @(posedge clk);
    end
    endtask
    // the flag note goes ahead of the opcode; the result note goes just before the last byte,
    // so the previous result has already been checked and taken off the queue
    task instr(input opcode_info_t oi, input logic [7:0] m, input logic [15:0] d);
        addr_regs_t r;
        logic [15:0] dx, ea, im;
        logic [1:0] md;
        logic [7:0] bq[$];
        logic wide;
    begin
        r = {$urandom, $urandom};
        im = 16'($urandom);
        md = oi.has_modrm ? m[7:6] : mod_reg;
        wide = md == mod_disp16 || (md == mod_disp0 && m[2:0] == rm_bp);
        dx = md == mod_disp8 ? {{8{d[7]}}, d[7:0]} : wide ? d : 16'h0000;
        case (m[2:0])
            rm_bx_si: ea = r.base_word_register + r.source_index;
            rm_bx_di: ea = r.base_word_register + r.destination_index;
            rm_bp_si: ea = r.base_pointer + r.source_index;
            rm_bp_di: ea = r.base_pointer + r.destination_index;
            rm_si: ea = r.source_index;
            rm_di: ea = r.destination_index;
            rm_bp: ea = md == mod_disp0 ? 16'h0000 : r.base_pointer;
            default: ea = r.base_word_register;
        endcase
        if (oi.flag_word_op) flag_q.push_back(~im);
        regs <= r;
        op_info <= oi;
        flag_word_in <= ~im;
        bq.delete();
        bq.push_back(8'($urandom));
        if (oi.has_modrm) bq.push_back(m);
        if (md == mod_disp8 || wide) bq.push_back(d[7:0]);
        if (wide) bq.push_back(d[15:8]);
        if (oi.imm_bytes == 2'h2) bq.push_back(im[7:0]);
        if (oi.imm_bytes == 2'h2) bq.push_back(im[15:8]);
        for (int k = 0; k < bq.size(); k++)
        begin
            if (k == bq.size() - 1 && k > 0)
                exp_q.push_back({md != mod_reg, oi.imm_bytes == 2'h2, oi.has_modrm ? m : 8'h00,
                    16'(ea + dx), dx, im});
            put(bq[k], k == 0);
        end
    end
    endtask
    always @(posedge clk)
    begin
        #1;
        if (flag_word_valid === 1'b1)
        begin
            check("flag_q", 16'(flag_q.size()), 16'h0001);
            check("flag", flag_word_out, flag_q.pop_front());
        end
        if (dec_out.valid === 1'b1)
        begin
            check("dec_q", 16'(exp_q.size()), 16'h0001);
            e = exp_q.pop_front();
            check("is_memory", 16'(dec_out.is_memory), 16'(e[57]));
            check("modrm", 16'(dec_out.modrm), 16'(e[55:48]));
            if (e[57]) check("ea", dec_out.effective_address, e[47:32]);
            if (e[57]) check("disp", dec_out.displacement, e[31:16]);
            if (e[56]) check("imm", dec_out.immediate, e[15:0]);
        end
    end
    initial
    begin
        #20000;
        errors++;
        end_sim();
    end
    initial
    begin
        void'($urandom(14));
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        instr(opcode_info_t'({1'b0, 2'h2, 1'b1}), 8'h00, 16'h0000);
        for (int i = 0; i < 32; i++)
            instr(opcode_info_t'({1'b1, (i[4] ^ i[3]) ? 2'h2 : 2'h0, 1'b0}), {i[4:3], 3'($urandom), i[2:0]},
                16'($urandom));
        // aborted instruction: a fresh opcode cuts it short
        put(8'h12, 1'b1);
        put(8'h80, 1'b0);
        instr(opcode_info_t'({1'b1, 2'h0, 1'b0}), 8'h83, 16'h00f0);
        put(8'hc3, 1'b0);
        byte_valid <= 1'b0;
        repeat (4) @(posedge clk);
        check("drain", 16'(exp_q.size() + flag_q.size()), 16'h0000);
        end_sim();
    end
endmodule

/* File: operand_address_decode_pkg.sv */
// package: addressing fields, selector codes, carriers for the operand address decoder
package operand_address_decode_pkg;
    localparam int unsigned word_w = 16;
    localparam int unsigned byte_w = 8;
    localparam logic [1:0] mod_disp0 = 2'h0;
    localparam logic [1:0] mod_disp8 = 2'h1;
    localparam logic [1:0] mod_disp16 = 2'h2;
    localparam logic [1:0] mod_reg = 2'h3;
    localparam logic [2:0] rm_bx_si = 3'h0;
    localparam logic [2:0] rm_bx_di = 3'h1;
    localparam logic [2:0] rm_bp_si = 3'h2;
    localparam logic [2:0] rm_bp_di = 3'h3;
    localparam logic [2:0] rm_si = 3'h4;
    localparam logic [2:0] rm_di = 3'h5;
    localparam logic [2:0] rm_bp = 3'h6;
    localparam logic [2:0] rm_bx = 3'h7;
    localparam int unsigned mod_lsb = 6;
    localparam int unsigned rm_lsb = 0;
    localparam logic [15:0] word_rst = 16'h0000;
    localparam logic [2:0] imm_max = 3'h2;

    // register values the address adder reads
    typedef struct packed {
        logic [15:0] base_word_register;
        logic [15:0] base_pointer;
        logic [15:0] source_index;
        logic [15:0] destination_index;
    } addr_regs_t;

    // per-instruction format supplied by the opcode decoder with the first byte
    typedef struct packed {
        logic has_modrm;
        logic [1:0] imm_bytes;
        logic flag_word_op;
    } opcode_info_t;

    // decoded result
    typedef struct packed {
        logic valid;
        logic is_memory;
        logic [15:0] effective_address;
        logic [15:0] displacement;
        logic [15:0] immediate;
        logic [7:0] modrm;
    } decode_out_t;
endpackage

/* File: operand_address_decode_sva.sv */
// checker: address sums, result spacing and flag word moves of the operand decoder
`timescale 1ns/1ps
module operand_address_decode_sva
import operand_address_decode_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic byte_valid,
    input wire logic [7:0] byte_data,
    input wire logic first_byte,
    input wire opcode_info_t op_info,
    input wire addr_regs_t regs,
    input wire logic [15:0] flag_word_in,
    input wire decode_out_t dec_out,
    input wire logic [15:0] flag_word_out,
    input wire logic flag_word_valid
);
    addr_regs_t q_r;
    logic v;
    logic [2:0] rm;
    logic [15:0] ea;
    logic [15:0] dp;
    // regs are read in the last byte's cycle, one edge before the result shows
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            q_r <= '0;
        else
            q_r <= regs;
    end
    assign v = dec_out.valid && dec_out.is_memory;
    assign rm = dec_out.modrm[2:0];
    assign ea = dec_out.effective_address;
    assign dp = dec_out.displacement;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_flag_op; byte_valid && first_byte && op_info.flag_word_op; endsequence
    sequence s_tail; $past(byte_valid && !first_byte) ##1 !dec_out.valid; endsequence
    // 16-bit compare drops the carry, as the adder must
    property p_bx_si; v && rm == rm_bx_si |-> ea == q_r.base_word_register + q_r.source_index + dp; endproperty
    a_bx_si: assert property (p_bx_si) else $error("sum for selector 000 wrong");
    property p_bp_di; v && rm == rm_bp_di |-> ea == q_r.base_pointer + q_r.destination_index + dp; endproperty
    a_bp_di: assert property (p_bp_di) else $error("sum for selector 011 wrong");
    property p_si; v && rm == rm_si |-> ea == q_r.source_index + dp; endproperty
    a_si: assert property (p_si) else $error("sum for selector 100 wrong");
    property p_di; v && rm == rm_di |-> ea == q_r.destination_index + dp; endproperty
    a_di: assert property (p_di) else $error("sum for selector 101 wrong");
    property p_bp; v && rm == rm_bp && dec_out.modrm[7:6] != mod_disp0 |-> ea == q_r.base_pointer + dp; endproperty
    a_bp: assert property (p_bp) else $error("sum for selector 110 wrong");
    property p_bx; v && rm == rm_bx |-> ea == q_r.base_word_register + dp; endproperty
    a_bx: assert property (p_bx) else $error("sum for selector 111 wrong");
    property p_flag; s_flag_op |=> flag_word_valid && flag_word_out == $past(flag_word_in); endproperty
    a_flag: assert property (p_flag) else $error("flag word not moved whole");
    property p_tail; dec_out.valid |-> s_tail; endproperty
    a_tail: assert property (p_tail) else $error("result not after a trailing byte");
endmodule
bind operand_address_decode operand_address_decode_sva u_sva (.clk, .rst_n, .byte_valid, .byte_data,
    .first_byte, .op_info, .regs, .flag_word_in, .dec_out, .flag_word_out, .flag_word_valid);
